/* rtl/foei_cfg.svh */
// Constants for the FIFO output extraction and interlock block
`ifndef FOEI_CFG_SVH
`define FOEI_CFG_SVH
`define FOEI_WORD_W 4
`define FOEI_SHIFTS 3'h4
`define FOEI_CNT_ZERO 3'h0
`define FOEI_CNT_ONE 3'h1
`define FOEI_PINS 8
`define FOEI_SYNC_RST 8'hf5
`define FOEI_PIN_ARST 0
`define FOEI_PIN_TOP 1
`define FOEI_PIN_TOS 2
`define FOEI_PIN_SERIAL_OUT_SHIFT_CLOCK 3
`define FOEI_PIN_IES 4
`define FOEI_PIN_OES 5
`define FOEI_PIN_TTS 6
`define FOEI_PIN_EO 7
`define FOEI_WORD_RST 4'h0
`define FOEI_FILL_BIT 1'h0
`define FOEI_BUF_CNT_W 2
`define FOEI_BUF_FULL 2'h2
`define FOEI_BUF_EMPTY 2'h0
`define FOEI_BUF_ONE 2'h1
`endif

/* rtl/foei_pkg.sv */
// Types shared by the FIFO output extraction block
package foei_pkg;
  typedef enum logic [1:0] {
    FOEI_OR_EMPTY = 2'h0,
    FOEI_OR_HELD = 2'h1,
    FOEI_OR_SHIFT = 2'h3
  } foei_or_state_type;
endpackage

/* rtl/foei_output.sv */
// Output register, serial shifter, two-entry buffer and array interlock
`timescale 1ns/1ps
`include "foei_cfg.svh"
module foei_output (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_array_reset_n,
  input wire logic i_parallel_transfer_out,
  input wire logic i_serial_transfer_out_n,
  input wire logic i_serial_out_shift_clock,
  input wire logic i_input_slave_enable_n,
  input wire logic i_output_slave_enable_n,
  input wire logic i_stack_load_request_n,
  input wire logic i_parallel_output_enable_n,
  input wire logic i_stack_valid,
  input wire logic [`FOEI_WORD_W-1:0] i_stack_data,
  input wire logic i_input_word_done,
  output logic o_stack_ready,
  output logic [`FOEI_WORD_W-1:0] o_parallel_data,
  output logic o_parallel_data_oe_n,
  output logic o_serial_data_out,
  output logic o_serial_data_oe_n,
  output logic o_output_empty_flag,
  output logic o_input_full_flag_n,
  output logic o_input_init,
  output logic o_master
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [`FOEI_PINS-1:0] pin_raw;
  logic [`FOEI_PINS-1:0] meta_reg;
  logic [`FOEI_PINS-1:0] sync_reg;
  logic serial_out_shift_clock_prev_reg;
  logic arst_n;
  logic top;
  logic tos_n;
  logic ies_n;
  logic oes_n;
  logic tts_n;
  logic serial_out_shift_clock_fall;

  // Gather pins so one vector assignment builds every two-stage chain
  always_comb begin
    pin_raw = '0;
    pin_raw[`FOEI_PIN_ARST] = i_array_reset_n;
    pin_raw[`FOEI_PIN_TOP] = i_parallel_transfer_out;
    pin_raw[`FOEI_PIN_TOS] = i_serial_transfer_out_n;
    pin_raw[`FOEI_PIN_SERIAL_OUT_SHIFT_CLOCK] = i_serial_out_shift_clock;
    pin_raw[`FOEI_PIN_IES] = i_input_slave_enable_n;
    pin_raw[`FOEI_PIN_OES] = i_output_slave_enable_n;
    pin_raw[`FOEI_PIN_TTS] = i_stack_load_request_n;
    pin_raw[`FOEI_PIN_EO] = i_parallel_output_enable_n;
  end

  // Two flops per pin; first stage feeds only the second
  // Whole vectors in one process, so each register has a single driver
  // Reset levels match each pin's idle level, so no false edge follows
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= `FOEI_SYNC_RST;
      sync_reg <= `FOEI_SYNC_RST;
    end else begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
    end
  end

  // Shift clock history for edge detection
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      serial_out_shift_clock_prev_reg <= 1'b0;
    end else begin
      serial_out_shift_clock_prev_reg <= sync_reg[`FOEI_PIN_SERIAL_OUT_SHIFT_CLOCK];
    end
  end

  // Sampled pin levels
  assign arst_n = sync_reg[`FOEI_PIN_ARST];
  assign top = sync_reg[`FOEI_PIN_TOP];
  assign tos_n = sync_reg[`FOEI_PIN_TOS];
  assign ies_n = sync_reg[`FOEI_PIN_IES];
  assign oes_n = sync_reg[`FOEI_PIN_OES];
  assign tts_n = sync_reg[`FOEI_PIN_TTS];
  assign serial_out_shift_clock_fall = serial_out_shift_clock_prev_reg & ~sync_reg[`FOEI_PIN_SERIAL_OUT_SHIFT_CLOCK];

  // ****************************************************************
  // Two-entry buffer between stack bottom and output register
  // ****************************************************************
  logic [`FOEI_WORD_W-1:0] buf_mem [0:1];
  logic buf_wr_reg;
  logic buf_rd_reg;
  logic [`FOEI_BUF_CNT_W-1:0] buf_cnt_reg;
  logic buf_push;
  logic buf_pop;
  logic buf_valid;

  // Ready and the flags are the only chaining interface
  assign o_stack_ready = arst_n & (buf_cnt_reg != `FOEI_BUF_FULL);
  assign buf_push = i_stack_valid & o_stack_ready;
  assign buf_valid = buf_cnt_reg != `FOEI_BUF_EMPTY;

  // Stored words survive array reset; only pointers and fill count are cleared
  always_ff @(posedge i_clk) begin
    if (buf_push) begin
      buf_mem[buf_wr_reg] <= i_stack_data;
    end
  end

  // Pointers and fill count; array reset empties the buffer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= `FOEI_BUF_EMPTY;
    end else if (!arst_n) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= `FOEI_BUF_EMPTY;
    end else begin
      if (buf_push) begin
        buf_wr_reg <= ~buf_wr_reg;
      end
      if (buf_pop) begin
        buf_rd_reg <= ~buf_rd_reg;
      end
      if (buf_push && !buf_pop) begin
        buf_cnt_reg <= buf_cnt_reg + `FOEI_BUF_ONE;
      end else if (!buf_push && buf_pop) begin
        buf_cnt_reg <= buf_cnt_reg - `FOEI_BUF_ONE;
      end
    end
  end

  // ****************************************************************
  // Master latch and input-side interlock
  // ****************************************************************
  logic master_reg;
  logic req_init_reg;
  logic in_full_reg;
  logic init_pulse;

  // Latch follows slave enable while array reset is held
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      master_reg <= 1'b0;
    end else if (!arst_n) begin
      master_reg <= ~ies_n;
    end
  end

  // Master inits at once, slave waits for enable low
  assign init_pulse = req_init_reg & (master_reg | ~ies_n);

  // Request flop set by load request, cleared by initialisation
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_init_reg <= 1'b0;
    end else if (!arst_n) begin
      req_init_reg <= 1'b0;
    end else if (!tts_n && in_full_reg && !init_pulse) begin
      req_init_reg <= 1'b1;
    end else if (init_pulse) begin
      req_init_reg <= 1'b0;
    end
  end

  // Word-held flag; new word wins over a clearing init
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_full_reg <= 1'b0;
    end else if (!arst_n) begin
      in_full_reg <= 1'b0;
    end else if (i_input_word_done) begin
      in_full_reg <= 1'b1;
    end else if (init_pulse) begin
      in_full_reg <= 1'b0;
    end
  end

  // Init strobe registered for the input register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_input_init <= 1'b0;
    end else begin
      o_input_init <= init_pulse & arst_n;
    end
  end

  assign o_input_full_flag_n = ~in_full_reg;
  assign o_master = master_reg;

  // ****************************************************************
  // Output register control
  // ****************************************************************
  foei_pkg::foei_or_state_type or_state_reg;
  foei_pkg::foei_or_state_type or_state_next;
  logic armed_reg;
  logic oes_seen_reg;
  logic qs_en_reg;
  logic [2:0] shift_cnt_reg;
  logic [`FOEI_WORD_W-1:0] word_reg;
  logic load;
  logic last_shift;
  logic top_fall;
  logic top_prev_reg;

  // Level request; both pins must agree, one load per arming
  assign load = (or_state_reg == foei_pkg::FOEI_OR_EMPTY) & top &
                ~tos_n & armed_reg & buf_valid & arst_n;
  assign buf_pop = load;
  assign last_shift = serial_out_shift_clock_fall &
                      (or_state_reg != foei_pkg::FOEI_OR_EMPTY) &
                      (shift_cnt_reg == `FOEI_SHIFTS - `FOEI_CNT_ONE);
  assign top_fall = top_prev_reg & ~top;

  // Parallel request history
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      top_prev_reg <= 1'b0;
    end else begin
      top_prev_reg <= top;
    end
  end

  // Re-armed by request low or by emptying via shifts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      armed_reg <= 1'b1;
    end else if (!arst_n) begin
      armed_reg <= 1'b1;
    end else if (!top || last_shift) begin
      armed_reg <= 1'b1;
    end else if (load) begin
      armed_reg <= 1'b0;
    end
  end

  // Next state of the output register
  always_comb begin
    or_state_next = or_state_reg;
    case (or_state_reg)
      foei_pkg::FOEI_OR_EMPTY: begin
        if (load) begin
          or_state_next = foei_pkg::FOEI_OR_HELD;
        end
      end
      foei_pkg::FOEI_OR_HELD: begin
        if (top_fall) begin
          or_state_next = foei_pkg::FOEI_OR_EMPTY;
        end else if (serial_out_shift_clock_fall) begin
          or_state_next = foei_pkg::FOEI_OR_SHIFT;
        end
      end
      foei_pkg::FOEI_OR_SHIFT: begin
        if (top_fall || last_shift) begin
          or_state_next = foei_pkg::FOEI_OR_EMPTY;
        end
      end
      default: begin
        or_state_next = foei_pkg::FOEI_OR_EMPTY;
      end
    endcase
  end

  // State register; array reset returns to empty
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      or_state_reg <= foei_pkg::FOEI_OR_EMPTY;
    end else if (!arst_n) begin
      or_state_reg <= foei_pkg::FOEI_OR_EMPTY;
    end else begin
      or_state_reg <= or_state_next;
    end
  end

  // Slave waits for output enable high after each load
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      oes_seen_reg <= 1'b0;
    end else if (!arst_n) begin
      oes_seen_reg <= 1'b0;
    end else if (oes_n) begin
      oes_seen_reg <= 1'b1; // Set wins over the load clear
    end else if (load) begin
      oes_seen_reg <= 1'b0;
    end
  end

  // Shift counter; counts falling edges since the load
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_cnt_reg <= `FOEI_CNT_ZERO;
    end else if (load || !arst_n) begin
      shift_cnt_reg <= `FOEI_CNT_ZERO;
    end else if (serial_out_shift_clock_fall &&
                 or_state_reg != foei_pkg::FOEI_OR_EMPTY) begin
      shift_cnt_reg <= shift_cnt_reg + `FOEI_CNT_ONE;
    end
  end

  // Data register; not cleared by array reset
  // Shift clock edges during a load are ignored, load takes priority
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      word_reg <= `FOEI_WORD_RST;
    end else if (load) begin
      word_reg <= buf_mem[buf_rd_reg];
    end else if (serial_out_shift_clock_fall &&
                 or_state_reg != foei_pkg::FOEI_OR_EMPTY) begin
      word_reg <= {`FOEI_FILL_BIT, word_reg[`FOEI_WORD_W-1:1]};
    end
  end

  // Serial output enabled on load, released when emptied
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      qs_en_reg <= 1'b0;
    end else if (!arst_n || last_shift || top_fall) begin
      qs_en_reg <= 1'b0;
    end else if (load) begin
      qs_en_reg <= 1'b1;
    end
  end

  // Parallel drivers follow the synchronised output enable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_parallel_data_oe_n <= 1'b1;
    end else begin
      o_parallel_data_oe_n <= sync_reg[`FOEI_PIN_EO];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Flag high only with a held word; slaves gated by enable
  assign o_output_empty_flag =
    (or_state_reg != foei_pkg::FOEI_OR_EMPTY) &
    (master_reg | oes_seen_reg);
  assign o_parallel_data = word_reg;
  assign o_serial_data_out = word_reg[0]; // First bit out is bit 0
  assign o_serial_data_oe_n = ~qs_en_reg;

endmodule // foei_output

/* bench/foei_output_assertions.sv */
// Port checks for the FIFO output extraction block
`timescale 1ns/1ps
`include "foei_cfg.svh"
module foei_output_assertions (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_array_reset_n,
  input wire logic i_parallel_transfer_out,
  input wire logic i_serial_out_shift_clock,
  input wire logic i_input_slave_enable_n,
  input wire logic i_output_slave_enable_n,
  input wire logic i_input_word_done,
  input wire logic [`FOEI_WORD_W-1:0] o_parallel_data,
  input wire logic o_serial_data_out,
  input wire logic o_serial_data_oe_n,
  input wire logic o_output_empty_flag,
  input wire logic o_input_full_flag_n,
  input wire logic o_input_init,
  input wire logic o_master
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  logic sclk_reg;
  logic [`FOEI_WORD_W-1:0] snap_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Word seen at each shift clock fall, our own edge finder
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_reg <= 1'h0;
      snap_reg <= `FOEI_WORD_RST;
    end else begin
      sclk_reg <= i_serial_out_shift_clock;
      if (sclk_reg && !i_serial_out_shift_clock) begin
        snap_reg <= o_parallel_data;
      end
    end
  end
  // ************************************************************
  // Assertions, windows allow for two-stage pin sync
  // ************************************************************
  flag_reset_a: assert property (!i_array_reset_n [*5] |-> !o_output_empty_flag)
    else $error("empty flag high during array reset");
  flag_rise_a: assert property ($rose(o_output_empty_flag) && o_master |->
    $past(i_parallel_transfer_out, 2)) else $error("flag rose without request");
  flag_drop_a: assert property ($fell(i_parallel_transfer_out) |->
    ##[1:4] !o_output_empty_flag) else $error("flag stayed high");
  data_hold_a: assert property (!i_parallel_transfer_out [*4] |->
    $stable(o_parallel_data)) else $error("output word changed while idle");
  flag_hold_a: assert property ((o_output_empty_flag && i_array_reset_n &&
    i_parallel_transfer_out && !i_serial_out_shift_clock) [*5] |=>
    o_output_empty_flag && $stable(o_parallel_data)) else $error("word reloaded");
  serial_oe_a: assert property ($rose(o_output_empty_flag) |->
    !o_serial_data_oe_n && o_serial_data_out == o_parallel_data[0])
    else $error("serial output not presented on load");
  shift_step_a: assert property (sclk_reg && !i_serial_out_shift_clock &&
    o_output_empty_flag |-> ##[2:4] o_parallel_data == (snap_reg >> 1))
    else $error("no single shift after clock fall");
  serial_done_a: assert property ($fell(o_output_empty_flag) &&
    i_parallel_transfer_out && i_array_reset_n |-> ##[0:1] o_serial_data_oe_n)
    else $error("serial output still driven when empty");
  slave_hold_a: assert property ((!o_master && !i_output_slave_enable_n) [*5]
    |-> !$rose(o_output_empty_flag)) else $error("slave flag rose early");
  master_set_a: assert property ((!i_array_reset_n &&
    !i_input_slave_enable_n) [*5] |-> o_master) else $error("master not set");
  slave_init_a: assert property ((!o_master && i_input_slave_enable_n) [*6]
    |-> !o_input_init) else $error("slave initialised without enable");
  full_flag_a: assert property (i_input_word_done |->
    ##[1:2] !o_input_full_flag_n) else $error("full flag not low");
  init_full_a: assert property ($rose(o_input_init) |-> o_input_full_flag_n)
    else $error("full flag low after init");
  cover property ($fell(o_output_empty_flag) ##1 o_serial_data_oe_n);
  cover property ($rose(o_output_empty_flag) && !o_master);
  cover property ($rose(o_input_init) && o_master);
endmodule // foei_output_assertions

/* bench/foei_consumer.sv */
// Serial consumer that clocks words out of the output block
`timescale 1ns/1ps
module foei_consumer (
  input wire logic i_go,
  input wire logic i_data,
  input wire logic i_data_oe_n,
  output logic o_shift_clock,
  output logic [3:0] o_word,
  output int o_frames
);
  logic bit_seen;
  // Clock rests low between frames so a load never shifts
  initial begin
    o_shift_clock = 1'h0;
    o_word = 4'h0;
    o_frames = 0;
    bit_seen = 1'h0;
  end
  // Four falls at 800 ns, LSB first; released line reads as the last bit inverted
  always @(posedge i_go) begin
    #50; // Move edges off the block's clock edge
    repeat (4) begin
      #400 o_shift_clock = 1'h1;
      bit_seen = i_data_oe_n ? ~bit_seen : i_data;
      #400 o_shift_clock = 1'h0;
      o_word = {bit_seen, o_word[3:1]};
    end
    o_frames = o_frames + 1;
  end
endmodule // foei_consumer

/* bench/fifo_output_extraction_interlock_tb.sv */
// Self-checking bench for the FIFO output extraction block
`timescale 1ns/1ps
`include "foei_cfg.svh"
module fifo_output_extraction_interlock_tb;
  logic i_clk, i_rst_b, i_array_reset_n, i_parallel_transfer_out;
  logic i_serial_transfer_out_n, i_serial_out_shift_clock, go;
  logic i_input_slave_enable_n, i_output_slave_enable_n, i_stack_valid;
  logic i_stack_load_request_n, i_parallel_output_enable_n;
  logic i_input_word_done, o_stack_ready, o_parallel_data_oe_n;
  logic o_serial_data_out, o_serial_data_oe_n, o_output_empty_flag;
  logic o_input_full_flag_n, o_input_init, o_master;
  logic [`FOEI_WORD_W-1:0] i_stack_data, o_parallel_data, got;
  int n_fail, compares, frames;
  foei_output u_dut (.*);
  foei_consumer u_cons (.i_go(go), .i_data(o_serial_data_out),
    .i_data_oe_n(o_serial_data_oe_n), .o_word(got), .o_frames(frames),
    .o_shift_clock(i_serial_out_shift_clock));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Bounded wait, judged afterwards by the caller
  task automatic wait_on(ref logic s, input logic v);
    for (int k = 0; k < 40 && s !== v; k++) @(negedge i_clk);
    @(posedge i_clk);
  endtask
  // Ready read mid-cycle, so it is the level the taking edge sees
  task automatic push(logic [3:0] w);
    logic r;
    i_stack_valid <= 1'h1;
    i_stack_data <= w;
    for (int k = 0; k < 40 && r !== 1'h1; k++) begin
      @(negedge i_clk);
      r = o_stack_ready;
      @(posedge i_clk);
    end
    i_stack_valid <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic array_reset(logic input_slave_enable_n);
    i_input_slave_enable_n <= input_slave_enable_n;
    i_array_reset_n <= 1'h0;
    tick(6);
    i_array_reset_n <= 1'h1;
    tick(4);
  endtask
  task automatic word_in();
    i_input_word_done <= 1'h1;
    tick(1);
    i_input_word_done <= 1'h0;
    tick(2);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_parallel();
    array_reset(1'h0); // Grounded enable makes a master
    check("empty_flag", 4'(o_output_empty_flag), 4'h0);
    check("master", 4'(o_master), 4'h1);
    check("par_oe_n", 4'(o_parallel_data_oe_n), 4'h0);
    push(4'h3);
    push(4'h5);
    check("stack_ready", 4'(o_stack_ready), 4'h0);
    i_parallel_transfer_out <= 1'h1;
    wait_on(o_output_empty_flag, 1'h1);
    check("data", o_parallel_data, 4'h3);
    tick(12);
    check("data", o_parallel_data, 4'h3);
    i_parallel_transfer_out <= 1'h0;
    wait_on(o_output_empty_flag, 1'h0);
    check("empty_flag", 4'(o_output_empty_flag), 4'h0);
    check("data", o_parallel_data, 4'h3);
    i_parallel_transfer_out <= 1'h1;
    wait_on(o_output_empty_flag, 1'h1);
    check("data", o_parallel_data, 4'h5);
    i_parallel_transfer_out <= 1'h0;
    tick(6);
  endtask
  task automatic t_level();
    i_parallel_transfer_out <= 1'h1;
    tick(6);
    i_parallel_transfer_out <= 1'h0;
    tick(6);
    check("empty_flag", 4'(o_output_empty_flag), 4'h0);
    i_parallel_transfer_out <= 1'h1;
    tick(6);
    push(4'h9);
    wait_on(o_output_empty_flag, 1'h1);
    check("data", o_parallel_data, 4'h9);
    i_parallel_transfer_out <= 1'h0;
    wait_on(o_output_empty_flag, 1'h0);
    i_parallel_transfer_out <= 1'h1;
    tick(4);
  endtask
  // Top held high, serial request tied low: words stream out
  task automatic t_serial(logic [3:0] w);
    int f;
    f = frames;
    check("ser_oe_n", 4'(o_serial_data_oe_n), 4'h1);
    push(w);
    wait_on(o_output_empty_flag, 1'h1);
    check("empty_flag", 4'(o_output_empty_flag), 4'h1);
    check("ser_oe_n", 4'(o_serial_data_oe_n), 4'h0);
    check("ser_bit", 4'(o_serial_data_out), 4'(w[0]));
    go <= 1'h1;
    for (int k = 0; k < 60 && frames == f; k++) tick(1);
    go <= 1'h0;
    check("ser_word", got, w);
    wait_on(o_output_empty_flag, 1'h0);
    check("empty_flag", 4'(o_output_empty_flag), 4'h0);
    check("ser_oe_n", 4'(o_serial_data_oe_n), 4'h1);
  endtask
  task automatic t_slave();
    i_parallel_transfer_out <= 1'h0;
    array_reset(1'h1);
    check("master", 4'(o_master), 4'h0);
    i_parallel_transfer_out <= 1'h1;
    push(4'hc);
    tick(10);
    check("empty_flag", 4'(o_output_empty_flag), 4'h0);
    i_output_slave_enable_n <= 1'h1;
    wait_on(o_output_empty_flag, 1'h1);
    check("data", o_parallel_data, 4'hc);
    word_in();
    check("full_n", 4'(o_input_full_flag_n), 4'h0);
    i_stack_load_request_n <= 1'h0;
    tick(10);
    check("full_n", 4'(o_input_full_flag_n), 4'h0);
    i_input_slave_enable_n <= 1'h0;
    wait_on(o_input_full_flag_n, 1'h1);
    check("full_n", 4'(o_input_full_flag_n), 4'h1);
    i_stack_load_request_n <= 1'h1;
    array_reset(1'h0);
    word_in();
    i_stack_load_request_n <= 1'h0;
    wait_on(o_input_full_flag_n, 1'h1);
    check("full_n", 4'(o_input_full_flag_n), 4'h1);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Clock at 10 MHz
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  // Runs well under 2000 cycles, so 6000 means a hang
  initial begin
    repeat (6000) @(posedge i_clk);
    n_fail++;
    report_and_stop();
  end
  // Main sequence; single device wiring for request pins
  // No expansion partners, so shared request wiring is idle
  initial begin
    {i_rst_b, i_array_reset_n, i_parallel_transfer_out, go} = 4'h4;
    {i_serial_transfer_out_n, i_input_slave_enable_n} = 2'h0;
    {i_output_slave_enable_n, i_parallel_output_enable_n} = 2'h0;
    {i_stack_load_request_n, i_stack_valid, i_input_word_done} = 3'h4;
    i_stack_data = 4'h0;
    tick(10);
    i_rst_b <= 1'h1;
    tick(3);
    t_parallel();
    t_level();
    t_serial(4'ha);
    t_serial(4'h6);
    t_slave();
    report_and_stop();
  end
endmodule // fifo_output_extraction_interlock_tb
bind foei_output foei_output_assertions u_chk (.*);
